//--- design/ett_pkg.sv
// Constants shared by the E1/T1 transmit path: register map, fields, codes
package ett_pkg;
  // Register indices; byte offset is four times the index
  localparam logic [4:0] IDX_GLB    = 5'h00;
  localparam logic [4:0] IDX_TGT    = 5'h01;
  localparam logic [4:0] IDX_TPL    = 5'h02;
  localparam logic [4:0] IDX_OE     = 5'h03;
  localparam logic [4:0] IDX_RAIL   = 5'h04;
  localparam logic [4:0] IDX_CODE   = 5'h05;
  localparam logic [4:0] IDX_PWDN   = 5'h06;
  localparam logic [4:0] IDX_ONES   = 5'h07;
  localparam logic [4:0] IDX_AUTO   = 5'h08;
  localparam logic [4:0] IDX_JAEN   = 5'h09;
  localparam logic [4:0] IDX_JAPOS  = 5'h0a;
  localparam logic [4:0] IDX_JADEP  = 5'h0b;
  localparam logic [4:0] IDX_JATRIP = 5'h0c;
  localparam logic [4:0] IDX_SPDIS  = 5'h0d;
  localparam logic [4:0] IDX_HAUL   = 5'h0e;
  localparam logic [4:0] IDX_BERT   = 5'h0f;
  localparam logic [4:0] IDX_CKINV  = 5'h10;
  localparam logic [4:0] IDX_BPV    = 5'h11;
  localparam logic [4:0] IDX_FLTST  = 5'h12;
  localparam logic [4:0] IDX_FLTIE  = 5'h13;
  localparam logic [4:0] IDX_FLTIS  = 5'h14;
  localparam int         NREG       = 21;
  // Plain read/write registers (bit set per index)
  localparam logic [20:0] RW_MAP    = 21'h09effb;
  localparam logic [31:0] REG_RST   = 32'h0000_0000;
  localparam logic [4:0]  TMPL_RST  = 5'h00;
  // Field positions
  localparam int GLB_AMI_BIT   = 0;
  localparam int TPL_MATCH_OFF = 3;
  localparam int TPL_CHOICE    = 4;
  localparam int TGT_W         = 4;
  // Template codes
  localparam logic [2:0] TMPL_E1     = 3'h0;
  localparam logic [2:0] TMPL_RSV_A  = 3'h1;
  localparam logic [2:0] TMPL_RSV_B  = 3'h2;
  localparam logic [2:0] TMPL_LH_RSV = 3'h7;
  // Impedance selection codes
  localparam logic [1:0] IMP_75  = 2'h0;
  localparam logic [1:0] IMP_120 = 2'h1;
  localparam logic [1:0] IMP_100 = 2'h2;
  localparam logic [1:0] IMP_110 = 2'h3;
  // Zero run lengths that trigger substitution
  localparam logic [3:0] B8ZS_RUN = 4'h8;
  localparam logic [3:0] HDB3_RUN = 4'h4;
  // Jitter attenuator depths and trip margin
  localparam logic [7:0] JA_DEPTH_SHALLOW = 8'h20;
  localparam logic [7:0] JA_DEPTH_DEEP    = 8'h80;
  localparam logic [7:0] JA_TRIP_MARGIN   = 8'h04;
endpackage

//--- design/ett_tx_path.sv
// Transmit digital path for NCH E1/T1 channels with APB control registers
// Notes on behaviour
// - Rail data is taken on the falling edge of the transmit clock, or on the rising edge when the invert bit is set.
// - Dual-rail mode passes both rails to the line unchanged, uncoded.
// - Single-rail uses positive rail only, coded AMI or B8ZS/HDB3.
// - Rail mode is chosen per channel.
// - A mapped BERT replaces system data in either rail mode.
// - Short-haul codes: 000 E1, 001/010 reserved, 011-111 DSX-1 lengths.
// - Long-haul codes: 000 E1, 001/010 reserved, 011-110 CSU levels.
// - Haul select per channel picks short or long template set.
// - Match can be disabled; choice bit picks 75/120 or 100/110 ohms.
// - Template register writes go to the channel the select register names.
// - BPV insertion per channel, only in single-rail mode.
// - Per-channel line code bit or the global AMI bit selects AMI coding.
// - All-ones forced by enable, or automatic on receiver loss of signal.
// - Jitter attenuator enable, path position and depth per channel.
// - Trip flag set when attenuator FIFO within 4 bits of limit.
// - Per-channel output enable and transmitter power-down.
// - Driver fault status with interrupt status and enable per channel.
// - Per-channel bit disables short-circuit protection.
// - Substitution on by default; E1 uses HDB3, T1 uses B8ZS.
// - All-ones sends continuous marks on master clock, ignoring rails.
`timescale 1ns/1ps
module ett_tx_path #(
  parameter int NCH    = 16,
  parameter int FILL_W = 8
) (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // System transmit side and master clock
  input  wire logic [NCH-1:0]        tx_system_clock_i,
  input  wire logic [NCH-1:0]        tx_positive_rail_in_i,
  input  wire logic [NCH-1:0]        tx_negative_rail_in_i,
  input  wire logic                  master_clock_i,
  input  wire logic                  bert_data_i,
  // Receiver, driver monitor and attenuator status
  input  wire logic [NCH-1:0]        rx_loss_of_signal_i,
  input  wire logic [NCH-1:0]        driver_fault_raw_i,
  input  wire logic [NCH*FILL_W-1:0] ja_fill_i,
  // Line side
  output logic      [NCH-1:0]        line_out_a_o,
  output logic      [NCH-1:0]        line_out_b_o,
  output logic      [NCH-1:0]        line_oe_o,
  // Analog front-end controls
  output logic      [NCH*4-1:0]      template_sel_o,
  output logic      [NCH-1:0]        template_reserved_o,
  output logic      [NCH-1:0]        tx_match_en_o,
  output logic      [NCH*2-1:0]      impedance_sel_o,
  output logic      [NCH-1:0]        ja_enable_o,
  output logic      [NCH-1:0]        ja_in_tx_path_o,
  output logic      [NCH-1:0]        ja_deep_o,
  output logic      [NCH-1:0]        short_limit_en_o,
  output logic                       driver_fault_alert_o
);

  localparam int SW = 5 * NCH + 1;
  localparam logic [31:0] CH_MASK = (NCH >= 32) ? 32'hffff_ffff : ((32'h1 << NCH) - 32'h1);

  // Register state
  logic [31:0]    cfg_q  [ett_pkg::NREG];
  logic [31:0]    cfg_d  [ett_pkg::NREG];
  logic [4:0]     tmpl_q [NCH];
  logic [4:0]     tmpl_d [NCH];
  logic [NCH-1:0] trip_q, trip_d, dfis_q, dfis_d, arm_q, arm_d, dfp_q, dfp_d;
  logic [31:0]    rdata_q, rdata_d, rd_val;
  logic           err_q, err_d;
  // Synchroniser state
  logic [SW-1:0]  s1_q, s2_q, s3_q, filt_q, prv_q, filt_d;
  // Cross-block signals
  logic [NCH-1:0] bpv_used, trip_set, ones_on;
  logic [4:0]     idx;
  logic           addr_ok, setup, wr;
  logic [NCH-1:0] clk_f, pos_f, neg_f, los_f, flt_f, clk_e;
  logic           mclk_evt;

  // Slices of the filtered pin vector
  assign clk_f    = filt_q[NCH-1:0];
  assign pos_f    = filt_q[2*NCH-1:NCH];
  assign neg_f    = filt_q[3*NCH-1:2*NCH];
  assign los_f    = filt_q[4*NCH-1:3*NCH];
  assign flt_f    = filt_q[5*NCH-1:4*NCH];
  assign clk_e    = filt_q[NCH-1:0] ^ prv_q[NCH-1:0];
  assign mclk_evt = filt_q[SW-1] & ~prv_q[SW-1];

  // Pin filter: new level accepted only when stages two and three agree
  always_comb begin
    filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  end

  // Three-stage sampling of clocks, rails, loss of signal and fault inputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
      prv_q  <= '0;
    end else begin
      s1_q   <= {master_clock_i, driver_fault_raw_i, rx_loss_of_signal_i,
                 tx_negative_rail_in_i, tx_positive_rail_in_i, tx_system_clock_i};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prv_q  <= filt_q;
    end
  end

  // APB decode; zero wait states, data registered during setup
  assign idx      = paddr_i[6:2];
  assign addr_ok  = ~paddr_i[7] && (32'(idx) < 32'(ett_pkg::NREG));
  assign setup    = psel_i & ~penable_i;
  assign wr       = psel_i & penable_i & pwrite_i & addr_ok;
  assign pready_o = 1'b1;
  assign prdata_o = rdata_q;
  assign pslverr_o = err_q & psel_i & penable_i;

  // Read mux; state registers show live block status
  always_comb begin
    case (idx)
      ett_pkg::IDX_TPL:    rd_val = {27'h0, tmpl_q[cfg_q[ett_pkg::IDX_TGT][ett_pkg::TGT_W-1:0]]};
      ett_pkg::IDX_JATRIP: rd_val = 32'(trip_q);
      ett_pkg::IDX_BPV:    rd_val = 32'(arm_q);
      ett_pkg::IDX_FLTST:  rd_val = 32'(flt_f);
      ett_pkg::IDX_FLTIS:  rd_val = 32'(dfis_q);
      default:             rd_val = addr_ok ? cfg_q[idx] : 32'h0;
    endcase
  end

  // Jitter attenuator trip compare per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      trip_set[c] = (8'(ja_fill_i[c*FILL_W +: FILL_W]) >=
                     ((cfg_q[ett_pkg::IDX_JADEP][c] ? ett_pkg::JA_DEPTH_DEEP : ett_pkg::JA_DEPTH_SHALLOW)
                      - ett_pkg::JA_TRIP_MARGIN));
    end
  end

  // Next register values; hardware set beats software clear
  always_comb begin
    logic [NCH-1:0] wmask;
    wmask   = pwdata_i[NCH-1:0];
    cfg_d   = cfg_q;
    tmpl_d  = tmpl_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      rdata_d = rd_val;
      err_d   = ~addr_ok;
    end
    for (int r = 0; r < ett_pkg::NREG; r++) begin
      if (wr && idx == 5'(r) && ett_pkg::RW_MAP[r]) begin
        cfg_d[r] = pwdata_i & CH_MASK;
      end
    end
    // template write lands on selected transmitter
    if (wr && idx == ett_pkg::IDX_TPL) begin
      tmpl_d[cfg_q[ett_pkg::IDX_TGT][ett_pkg::TGT_W-1:0]] = pwdata_i[4:0];
    end
    // sticky trip, write one to clear
    trip_d = (trip_q & ~((wr && idx == ett_pkg::IDX_JATRIP) ? wmask : '0)) | trip_set;
    dfp_d  = flt_f;
    dfis_d = (dfis_q & ~((wr && idx == ett_pkg::IDX_FLTIS) ? wmask : '0)) | (flt_f ^ dfp_q);
    // pending violation until the channel uses it
    arm_d  = (arm_q & ~bpv_used) | ((wr && idx == ett_pkg::IDX_BPV) ? wmask : '0);
  end

  // Register file flops
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int r = 0; r < ett_pkg::NREG; r++) cfg_q[r] <= ett_pkg::REG_RST;
      for (int c = 0; c < NCH; c++) tmpl_q[c] <= ett_pkg::TMPL_RST;
      trip_q  <= '0;
      dfis_q  <= '0;
      dfp_q   <= '0;
      arm_q   <= '0;
      rdata_q <= '0;
      err_q   <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      tmpl_q  <= tmpl_d;
      trip_q  <= trip_d;
      dfis_q  <= dfis_d;
      dfp_q   <= dfp_d;
      arm_q   <= arm_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // enabled fault status raises the alert
  assign driver_fault_alert_o = |(dfis_q & cfg_q[ett_pkg::IDX_FLTIE][NCH-1:0]);
  assign ones_on = cfg_q[ett_pkg::IDX_ONES][NCH-1:0] | (cfg_q[ett_pkg::IDX_AUTO][NCH-1:0] & los_f);
  assign ja_enable_o     = cfg_q[ett_pkg::IDX_JAEN][NCH-1:0];
  assign ja_in_tx_path_o = cfg_q[ett_pkg::IDX_JAPOS][NCH-1:0];
  assign ja_deep_o       = cfg_q[ett_pkg::IDX_JADEP][NCH-1:0];
  // current limit only on a fault and if not disabled
  assign short_limit_en_o = flt_f & ~cfg_q[ett_pkg::IDX_SPDIS][NCH-1:0];
  // driver on only when enabled and not powered down
  assign line_oe_o = cfg_q[ett_pkg::IDX_OE][NCH-1:0] & ~cfg_q[ett_pkg::IDX_PWDN][NCH-1:0];

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [15:0] pipe_q, pipe_d;
    logic [3:0]  zc_q, zc_d;
    logic        last_q, last_d, odd_q, odd_d;
    logic        a_q, a_d, b_q, b_d, used;
    logic        bit_evt, single, ami, e1, haul, din;
    logic [2:0]  code;

    assign code = tmpl_q[g][2:0];
    assign haul = cfg_q[ett_pkg::IDX_HAUL][g];
    assign e1   = (code == ett_pkg::TMPL_E1);
    assign template_sel_o[g*4 +: 4] = {haul, code};
    assign template_reserved_o[g]   = (code == ett_pkg::TMPL_RSV_A) || (code == ett_pkg::TMPL_RSV_B) ||
                                      (haul && code == ett_pkg::TMPL_LH_RSV);
    assign tx_match_en_o[g] = ~tmpl_q[g][ett_pkg::TPL_MATCH_OFF];
    assign impedance_sel_o[g*2 +: 2] = e1 ? (tmpl_q[g][ett_pkg::TPL_CHOICE] ? ett_pkg::IMP_120 : ett_pkg::IMP_75)
                                          : (tmpl_q[g][ett_pkg::TPL_CHOICE] ? ett_pkg::IMP_110 : ett_pkg::IMP_100);
    // invert bit moves sampling to rising edge
    assign bit_evt = clk_e[g] & (clk_f[g] == cfg_q[ett_pkg::IDX_CKINV][g]);
    assign single  = cfg_q[ett_pkg::IDX_RAIL][g];
    assign ami     = cfg_q[ett_pkg::IDX_GLB][ett_pkg::GLB_AMI_BIT] | cfg_q[ett_pkg::IDX_CODE][g];
    // tester data replaces the system rail
    assign din     = cfg_q[ett_pkg::IDX_BERT][g] ? bert_data_i : pos_f[g];
    assign bpv_used[g]     = used;
    assign line_out_a_o[g] = a_q;
    assign line_out_b_o[g] = b_q;

    // Encoder: eight-symbol pipeline so a zero run can be rewritten
    always_comb begin
      logic pol;
      pol    = last_q;
      pipe_d = pipe_q;
      zc_d   = zc_q;
      last_d = last_q;
      odd_d  = odd_q;
      a_d    = a_q;
      b_d    = b_q;
      used   = 1'b0;
      if (ones_on[g]) begin
        // alternating marks on master clock, rails ignored
        if (mclk_evt) begin
          // Polarity follows the line itself, so entry from a mark never repeats it; entry from a space starts positive
          a_d = ~a_q;
          b_d = a_q;
        end
      end else if (bit_evt) begin
        if (!single) begin
          a_d = cfg_q[ett_pkg::IDX_BERT][g] ? bert_data_i : pos_f[g];
          b_d = cfg_q[ett_pkg::IDX_BERT][g] ? 1'b0 : neg_f[g];
        end else begin
          a_d = pipe_q[15] & ~pipe_q[14];
          b_d = pipe_q[15] & pipe_q[14];
          if (din) begin
            if (arm_q[g]) begin
              used = 1'b1;
            end else begin
              pol = ~last_q;
            end
            last_d = pol;
            odd_d  = ~odd_q;
            zc_d   = 4'h0;
            pipe_d = {pipe_q[13:0], 1'b1, pol};
          end else begin
            zc_d   = zc_q + 4'h1;
            pipe_d = {pipe_q[13:0], 2'b00};
          end
          // substitution unless AMI; B8ZS for T1
          if (!ami && !e1 && zc_d == ett_pkg::B8ZS_RUN) begin
            pipe_d[9:8] = {1'b1, last_q};
            pipe_d[7:6] = {1'b1, ~last_q};
            pipe_d[3:2] = {1'b1, ~last_q};
            pipe_d[1:0] = {1'b1, last_q};
            zc_d        = 4'h0;
          // HDB3 for E1, B00V keeps V polarity alternating
          end else if (!ami && e1 && zc_d == ett_pkg::HDB3_RUN) begin
            if (odd_q) begin
              pipe_d[1:0] = {1'b1, last_q};
            end else begin
              pipe_d[7:6] = {1'b1, ~last_q};
              pipe_d[1:0] = {1'b1, ~last_q};
              last_d      = ~last_q;
            end
            odd_d = 1'b0;
            zc_d  = 4'h0;
          end
        end
      end
    end

    // Encoder flops
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        pipe_q <= '0;
        zc_q   <= '0;
        last_q <= 1'b1;
        odd_q  <= 1'b0;
        a_q    <= 1'b0;
        b_q    <= 1'b0;
      end else begin
        pipe_q <= pipe_d;
        zc_q   <= zc_d;
        last_q <= last_d;
        odd_q  <= odd_d;
        a_q    <= a_d;
        b_q    <= b_d;
      end
    end

    // Line checks per channel
    dual_pass_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      bit_evt && !single && !ones_on[g] && !cfg_q[ett_pkg::IDX_BERT][g] |=> a_q == $past(pos_f[g]) && b_q == $past(neg_f[g]))
      else $error("dual rail data not passed");
    single_rail_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      single && !ones_on[g] |=> !(a_q && b_q))
      else $error("both line outputs marked");
    ones_mark_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ones_on[g] && mclk_evt |=> (a_q ^ b_q) && (a_q != $past(a_q)))
      else $error("all ones mark missing");
    bpv_single_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      used |-> single && bit_evt && !ones_on[g])
      else $error("violation used outside single rail");
    sample_edge_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      bit_evt |-> $past(clk_f[g]) != cfg_q[ett_pkg::IDX_CKINV][g])
      else $error("data sampled on wrong clock edge");
    zero_run_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !ami && single |-> zc_q < ett_pkg::B8ZS_RUN)
      else $error("zero run not substituted");
  end

  // Register-side checks
  fault_latch_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(flt_f[0]) |=> dfis_q[0])
    else $error("fault change not latched");
  trip_flag_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    trip_set[0] |=> trip_q[0] [*2])
    else $error("trip flag not held");
  power_down_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cfg_q[ett_pkg::IDX_PWDN][0] |-> !line_oe_o[0])
    else $error("powered down channel driving");
  auto_ones_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cfg_q[ett_pkg::IDX_AUTO][0] && los_f[0] && mclk_evt |=> line_out_a_o[0] ^ line_out_b_o[0])
    else $error("auto all ones not sent");

endmodule // ett_tx_path

//--- sim/ett_framer_model.sv
// Behavioural framer that drives channel 0 transmit clock and NRZ rails
`timescale 1ns/1ps
module ett_framer_model (
  // Frame control and bit patterns
  input  wire logic       run_i,
  input  wire logic [7:0] pos_pat_i,
  input  wire logic [7:0] neg_pat_i,
  // Transmit clock and rails
  output logic            tx_system_clock_o,
  output logic            pos_o,
  output logic            neg_o
);
  logic [2:0] idx_q;
  // Clock runs at 80 ns within a frame only and parks high between frames
  initial begin
    tx_system_clock_o = 1'b1;
    pos_o  = 1'b0;
    neg_o  = 1'b0;
    idx_q  = 3'h0;
    forever begin
      #40;
      if (run_i || !tx_system_clock_o) tx_system_clock_o = ~tx_system_clock_o;
    end
  end
  // First bit is ready before the first fall of the frame
  always @(posedge run_i) begin
    pos_o <= pos_pat_i[0];
    neg_o <= neg_pat_i[0];
    idx_q <= 3'h1;
  end
  // stable at fall
  // Rails move on the rise, half a period clear of the sampling fall
  always @(posedge tx_system_clock_o) begin
    if (run_i) begin
      pos_o <= pos_pat_i[idx_q];
      neg_o <= neg_pat_i[idx_q];
      idx_q <= idx_q + 3'h1;
    end
  end
  // Released rails flip so a stale bit can never pass for a held one
  always @(negedge run_i) begin
    pos_o <= ~pos_o;
    neg_o <= ~neg_o;
  end
endmodule // ett_framer_model

//--- sim/ett_tx_path_tb_top.sv
// Self-checking bench for the E1/T1 transmit path
`timescale 1ns/1ps
module ett_tx_path_tb_top;
  logic         clk, rst, psel, pen, pwr, prdy, perr, ev, mclk, run, alert, fc, fp, fn, bert;
  logic [7:0]   paddr, pp, np;
  logic [31:0]  pwd, prd, rdv, isel;
  logic [15:0]  lra, lrb, loe, los, dfr, trsv, men, jen, jtx, jdp, slim;
  logic [127:0] fill;
  logic [63:0]  tsel;
  int           err_total, n_tests;

  ett_tx_path u_ett_tx_path (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .tx_system_clock_i({15'h7fff, fc}), .tx_positive_rail_in_i({15'h0000, fp}), .tx_negative_rail_in_i({15'h0000, fn}),
    .master_clock_i(mclk), .bert_data_i(bert), .rx_loss_of_signal_i(los), .driver_fault_raw_i(dfr),
    .ja_fill_i(fill), .line_out_a_o(lra), .line_out_b_o(lrb), .line_oe_o(loe), .template_sel_o(tsel),
    .template_reserved_o(trsv), .tx_match_en_o(men), .impedance_sel_o(isel), .ja_enable_o(jen),
    .ja_in_tx_path_o(jtx), .ja_deep_o(jdp), .short_limit_en_o(slim), .driver_fault_alert_o(alert));
  ett_framer_model u_ett_framer_model (.run_i(run), .pos_pat_i(pp), .neg_pat_i(np), .tx_system_clock_o(fc), .pos_o(fp),
    .neg_o(fn));

  // System clock and an unrelated master clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    mclk = 1'b0;
    forever #61 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    pwr   <= wr;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdv = prd;
    ev  = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    apb(1'b1, {1'b0, i, 2'b00}, d);
    // Let the written value settle before anyone looks at outputs
    @(negedge clk);
  endtask

  task automatic rdc(input logic [4:0] i, input logic [31:0] e);
    apb(1'b0, {1'b0, i, 2'b00}, 32'h0000_0000);
    chk(rdv, e);
    chk({31'h0, ev}, 32'h0000_0000);
  endtask

  // Reset values, read-only status and unmapped addresses
  task automatic t_regs();
    for (int i = 0; i < ett_pkg::NREG; i++) rdc(i[4:0], ett_pkg::REG_RST);
    wr(ett_pkg::IDX_FLTST, 32'hffff_ffff);
    rdc(ett_pkg::IDX_FLTST, 32'h0000_0000);
    apb(1'b0, 8'h54, 32'h0000_0000);
    chk({ev, rdv[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h80, 32'h0000_0000);
    chk({31'h0, ev}, 32'h0000_0001);
  endtask

  // Every template code in both haul sets on channel 3 only
  task automatic t_tmpl();
    logic [2:0] c;
    logic       rsv;
    wr(ett_pkg::IDX_TGT, 32'h0000_0003);
    for (int h = 0; h < 2; h++) begin
      wr(ett_pkg::IDX_HAUL, h[0] ? 32'h0000_0008 : 32'h0000_0000);
      for (int k = 0; k < 8; k++) begin
        c = k[2:0];
        rsv = (c == 3'h1) || (c == 3'h2) || (h[0] && c == 3'h7);
        wr(ett_pkg::IDX_TPL, {27'h0, c[0], c[1], c});
        repeat (2) @(posedge clk);
        chk({20'h0, tsel[15:12], trsv[3], men[3], isel[7:6], tsel[11:8]},
            {20'h0, h[0], c, rsv, ~c[1], c != 3'h0, c[0], 4'h0});
        rdc(ett_pkg::IDX_TPL, {27'h0, c[0], c[1], c});
      end
    end
  endtask

  // Output enable gated by power-down; attenuator controls and trip
  task automatic t_ctrl();
    wr(ett_pkg::IDX_OE, 32'h0000_0003);
    wr(ett_pkg::IDX_PWDN, 32'h0000_0002);
    chk({16'h0, loe}, 32'h0000_0001);
    wr(ett_pkg::IDX_JAEN, 32'h0000_0001);
    wr(ett_pkg::IDX_JAPOS, 32'h0000_0001);
    wr(ett_pkg::IDX_JADEP, 32'h0000_0002);
    chk({29'h0, jen[0], jtx[0], jdp[1]}, 32'h0000_0007);
    fill[7:0] <= ett_pkg::JA_DEPTH_SHALLOW - ett_pkg::JA_TRIP_MARGIN - 8'h01;
    repeat (4) @(posedge clk);
    rdc(ett_pkg::IDX_JATRIP, 32'h0000_0000);
    fill[7:0] <= ett_pkg::JA_DEPTH_SHALLOW - ett_pkg::JA_TRIP_MARGIN;
    repeat (4) @(posedge clk);
    rdc(ett_pkg::IDX_JATRIP, 32'h0000_0001);
  endtask

  // Driver fault status, interrupt pair and protection disable
  task automatic t_fault();
    wr(ett_pkg::IDX_FLTIE, 32'h0000_0001);
    dfr <= 16'h0001;
    repeat (10) @(posedge clk);
    rdc(ett_pkg::IDX_FLTST, 32'h0000_0001);
    rdc(ett_pkg::IDX_FLTIS, 32'h0000_0001);
    chk({30'h0, alert, slim[0]}, 32'h0000_0003);
    wr(ett_pkg::IDX_SPDIS, 32'h0000_0001);
    wr(ett_pkg::IDX_FLTIS, 32'h0000_0001);
    @(posedge clk);
    chk({30'h0, alert, slim[0]}, 32'h0000_0000);
  endtask

  // Run one frame on channel 0, recording the line at each clock rise
  task automatic frame(input logic [7:0] p, input logic [7:0] n, input int nb, output logic [31:0] a,
                       output logic [31:0] b);
    @(posedge clk);
    pp  <= p;
    np  <= n;
    run <= 1'b1;
    for (int k = 0; k < nb; k++) begin
      @(posedge fc);
      a[k] = lra[0];
      b[k] = lrb[0];
    end
    @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
  endtask

  // Dual-rail pass-through, single-rail AMI and default substitution
  task automatic t_line();
    logic [31:0] a, b;
    wr(ett_pkg::IDX_RAIL, 32'h0000_0000);
    frame(8'h96, 8'h3c, 8, a, b);
    chk({16'h0, a[7:0], b[7:0]}, 32'h0000_963c);
    // Mapped tester drives the positive rail, negative rail quiet
    wr(ett_pkg::IDX_BERT, 32'h0000_0001);
    bert <= 1'b1;
    frame(8'h00, 8'hff, 8, a, b);
    chk({16'h0, a[7:0], b[7:0]}, 32'h0000_ff00);
    wr(ett_pkg::IDX_BERT, 32'h0000_0000);
    wr(ett_pkg::IDX_RAIL, 32'h0000_0001);
    wr(ett_pkg::IDX_CODE, 32'h0000_0001);
    frame(8'h55, 8'hff, 16, a, b);
    // Marks alternate and the negative rail never shows through
    for (int k = 10; k < 16; k++) chk({30'h0, a[k] ^ b[k], a[k] ^ a[k-2]}, {30'h0, ~k[0], ~k[0]});
    wr(ett_pkg::IDX_CODE, 32'h0000_0000);
    frame(8'h00, 8'h00, 24, a, b);
    chk({31'h0, |(a[23:8] | b[23:8])}, 32'h0000_0001);
  endtask

  // Marks on the master clock, alternating, whatever the rails hold
  task automatic ones_chk();
    logic last;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    last = lra[0];
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      chk({30'h0, lra[0] ^ lrb[0], lra[0] ^ last}, 32'h0000_0003);
      last = lra[0];
    end
  endtask

  task automatic t_ones();
    wr(ett_pkg::IDX_ONES, 32'h0000_0001);
    ones_chk();
    wr(ett_pkg::IDX_ONES, 32'h0000_0000);
    wr(ett_pkg::IDX_AUTO, 32'h0000_0001);
    los <= 16'h0001;
    ones_chk();
    los <= 16'h0000;
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    rst = 1'b1;
    {psel, pen, pwr, run, bert} = 5'h00;
    {paddr, pp, np, pwd} = 56'h0;
    {los, dfr} = 32'h0;
    fill = 128'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tmpl();
    t_ctrl();
    t_fault();
    t_line();
    t_ones();
    close_out();
  end

  // Watchdog well beyond the expected run of about 10 us
  initial begin
    #300000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule // ett_tx_path_tb_top
